// ---- rf_modem_param_command.sv ----
// Decided for this implementation: the APB register port and the address map.
module rf_modem_param_command
    import rf_param_pkg::*;
#(
    parameter logic [7:0] INVALID_STATUS = 8'hFF
) (
    // Clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Command byte stream from the serial framer
    input  wire logic              frame_active,
    input  wire logic              rx_valid,
    input  wire logic [7:0]        rx_byte,
    output logic                   tx_valid,
    output logic      [7:0]        tx_byte,
    // Device state
    input  wire logic [7:0]        device_status,
    input  wire logic              tag_sleep,
    input  wire logic              tag_killed,
    input  wire logic              tag_open,
    input  wire logic              query_rx,
    input  wire logic              boot_seq_done,
    input  wire logic              serial_boot_cmd,
    input  wire logic              external_command_pending,
    output logic                   sleep_request,
    // Link clock sources and output
    input  wire logic              osc_tick,
    input  wire logic              blf_tick,
    output logic                   link_clk,
    // Settings to the protocol engine
    output ctrl_word_s             params,
    output logic      [1:0]        sens_sel,
    output logic                   req_rn_reject,
    output logic                   select_mask_only,
    output logic                   t2_skip,
    output logic                   ack_device,
    output logic                   xpc_disable
);

    // ============================================================
    // State
    parse_e            st_q;
    parse_e            st_d;
    logic [CTRL_W-1:0] ctrl_q;
    logic [15:0]       word_q;
    logic [7:0]        hi_q;
    logic [7:0]        lo_q;
    logic [15:0]       idle_q;
    logic              loaded_q;
    logic              prequery_q;
    logic              invalid_q;
    logic [7:0]        reply_q;
    logic              tx_valid_q;
    logic [31:0]       prdata_q;

    // ============================================================
    // Configuration decode
    wire cfg_modem    = ctrl_q[CTRL_RF_MODEM];
    wire cfg_bypassed = ctrl_q[CTRL_BYPASSED];
    wire cfg_shared   = ctrl_q[CTRL_SHARED];
    wire cfg_limited  = ctrl_q[CTRL_LIMITED];
    wire cmd_ok       = cfg_modem && (cfg_bypassed || cfg_shared);

    // ============================================================
    // Command parser
    wire byte_in    = ce && frame_active && rx_valid;
    wire last_byte  = byte_in && (st_q == ST_DUMMY);
    wire commit     = last_byte && cmd_ok;
    wire reject     = last_byte && !cmd_ok;
    // Reserved feature bits are dropped on the way in
    wire [15:0] new_word = {hi_q, lo_q} & {8'hFF, FEAT_KEEP_MASK};

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_CMD:   st_d = (rx_byte == CMD_SET_PARAMS) ? ST_HI : ST_SKIP;
            ST_HI:    st_d = ST_LO;
            ST_LO:    st_d = ST_DUMMY;
            ST_DUMMY: st_d = ST_SKIP;
            ST_SKIP:  st_d = ST_SKIP;
            default:  st_d = ST_SKIP;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_CMD;
        end else if (ce) begin
            // A new frame always restarts at the command byte
            if (!frame_active) begin
                st_q <= ST_CMD;
            end else if (rx_valid) begin
                st_q <= st_d;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 8'h00;
            lo_q <= 8'h00;
        end else if (byte_in && st_q == ST_HI) begin
            hi_q <= rx_byte;
        end else if (byte_in && st_q == ST_LO) begin
            // Held until the dummy byte completes the frame
            lo_q <= rx_byte;
        end
    end

    // ============================================================
    // Parameter word, loaded flag, pre-query window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_q   <= PARAM_RESET;
            loaded_q <= 1'b0;
        end else if (ce) begin
            if (commit) begin
                word_q   <= new_word;
                loaded_q <= 1'b1;
            end else if (serial_boot_cmd) begin
                word_q   <= PARAM_RESET;
                loaded_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prequery_q <= 1'b1;
        end else if (ce) begin
            // Boot wins over a Query landing in the same cycle
            if (boot_seq_done || serial_boot_cmd) begin
                prequery_q <= 1'b1;
            end else if (query_rx) begin
                prequery_q <= 1'b0;
            end
        end
    end

    // ============================================================
    // Reply byte, one per parameter frame that reaches the dummy byte, rejected ones included
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reply_q    <= REPLY_RESET;
            tx_valid_q <= 1'b0;
        end else if (ce) begin
            tx_valid_q <= last_byte;
            if (last_byte) begin
                reply_q <= cmd_ok ? device_status : INVALID_STATUS;
            end
        end
    end

    assign tx_valid = tx_valid_q;
    assign tx_byte  = reply_q;

    // ============================================================
    // Settings decode
    assign params           = ctrl_word_s'(word_q);
    assign sens_sel         = params.sens;
    assign req_rn_reject    = params.feat.no_req_rn && cfg_shared && cfg_limited;
    assign select_mask_only = params.feat.no_sel_mem;
    assign t2_skip          = params.feat.no_t2 && cfg_shared;
    assign ack_device       = !(params.feat.ack_shared && cfg_shared && cfg_limited
                                && tag_open);
    assign xpc_disable      = params.feat.no_xpc;

    // ============================================================
    // Idle timeout and link clock
    idle_timer u_idle (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .enable  (params.idle_en && cfg_shared),
        .pending (external_command_pending),
        .limit   (idle_q),
        .expire  (sleep_request)
    );

    link_clk_gen u_clk (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .sel       (params.clk_sel),
        .pre_query (prequery_q),
        .quiet     (tag_sleep || tag_killed),
        .osc_tick  (osc_tick),
        .blf_tick  (blf_tick),
        .link_clk  (link_clk)
    );

    // ============================================================
    // APB slave: read data captured in setup, no wait states
    wire setup    = psel && !penable;
    wire access   = psel && penable;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_par  = (paddr == OFS_PARAMS);
    wire hit_stat = (paddr == OFS_STATUS);
    wire hit_idle = (paddr == OFS_IDLE);
    wire mapped   = hit_ctrl || hit_par || hit_stat || hit_idle;
    wire wr       = ce && access && pwrite;
    wire clr_inv  = wr && hit_stat && pwdata[STAT_INVALID];

    wire [31:0] rd_mux =
        hit_ctrl ? {28'h0000000, ctrl_q} :
        hit_par  ? {15'h0000, loaded_q, word_q} :
        hit_stat ? {20'h00000, invalid_q, link_clk, prequery_q, loaded_q, reply_q} :
        hit_idle ? {16'h0000, idle_q} : 32'h00000000;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= CTRL_RESET;
            idle_q    <= IDLE_RESET;
            invalid_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else if (ce) begin
            if (wr && hit_ctrl) begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end
            if (wr && hit_idle) begin
                idle_q <= pwdata[15:0];
            end
            // A rejected frame in the clearing cycle keeps the flag
            invalid_q <= reject || (invalid_q && !clr_inv);
            if (setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // ============================================================
    // Checks
    reply_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
        last_byte |=> tx_valid)
        else $error("no reply after dummy byte");

    bad_cfg_reply_a: assert property (@(posedge pclk) disable iff (!presetn)
        reject |=> (tx_byte == INVALID_STATUS) && $stable(word_q))
        else $error("command accepted in wrong configuration");

    word_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        commit |=> (word_q == $past(new_word)) && loaded_q)
        else $error("parameter word not loaded");

    word_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !commit && !(ce && serial_boot_cmd) |=> $stable(word_q))
        else $error("parameter word changed without cause");

    boot_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && serial_boot_cmd && !commit |=> word_q == PARAM_RESET && prequery_q)
        else $error("boot did not clear parameters");

    single_reply_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_valid |=> !tx_valid)
        else $error("reply longer than one cycle");

    rsv_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
        (word_q & ~{8'hFF, FEAT_KEEP_MASK}) == 16'h0000)
        else $error("reserved feature bits stored");

    ack_open_a: assert property (@(posedge pclk) disable iff (!presetn)
        params.feat.ack_shared && cfg_shared && cfg_limited && tag_open |-> !ack_device)
        else $error("device kept ACK in Open state");

    req_rn_scope_a: assert property (@(posedge pclk) disable iff (!presetn)
        req_rn_reject |-> cfg_shared && cfg_limited && params.feat.no_req_rn)
        else $error("Req_RN rejected outside limited shared mode");

    t2_scope_a: assert property (@(posedge pclk) disable iff (!presetn)
        t2_skip |-> cfg_shared)
        else $error("T2 skipped outside shared mode");

    sleep_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_request |-> params.idle_en && cfg_shared)
        else $error("idle expiry while disabled");

    invalid_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        reject |=> invalid_q)
        else $error("invalid flag lost");

    load_cov: cover property (@(posedge pclk) disable iff (!presetn) commit);
    reject_cov: cover property (@(posedge pclk) disable iff (!presetn) reject);
    idle_cov: cover property (@(posedge pclk) disable iff (!presetn) sleep_request);
    clk_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(link_clk) && !prequery_q);

endmodule

// ---- rf_param_pkg.sv ----
package rf_param_pkg;

    // ============================================================
    // Command framing
    localparam logic [7:0] CMD_SET_PARAMS = 8'hF3;
    localparam logic [7:0] DUMMY_BYTE     = 8'h00;

    // ============================================================
    // Register map (byte addresses) and field positions
    localparam int unsigned  ADDR_W      = 8;
    localparam logic [7:0]   OFS_CTRL    = 8'h00;
    localparam logic [7:0]   OFS_PARAMS  = 8'h04;
    localparam logic [7:0]   OFS_STATUS  = 8'h08;
    localparam logic [7:0]   OFS_IDLE    = 8'h0C;
    localparam int unsigned  CTRL_RF_MODEM  = 0;
    localparam int unsigned  CTRL_BYPASSED  = 1;
    localparam int unsigned  CTRL_SHARED    = 2;
    localparam int unsigned  CTRL_LIMITED   = 3;
    localparam int unsigned  CTRL_W         = 4;
    localparam int unsigned  PARAMS_LOADED  = 16;
    localparam int unsigned  STAT_LOADED    = 8;
    localparam int unsigned  STAT_PREQUERY  = 9;
    localparam int unsigned  STAT_LINK_CLK  = 10;
    localparam int unsigned  STAT_INVALID   = 11;

    // ============================================================
    // Reset values
    localparam logic [3:0]   CTRL_RESET   = 4'h0;
    localparam logic [15:0]  PARAM_RESET  = 16'h0000;
    localparam logic [15:0]  IDLE_RESET   = 16'h0000;
    localparam logic [7:0]   REPLY_RESET  = 8'h00;

    // ============================================================
    // Timing
    localparam int unsigned  CLK_PERIOD_NS    = 40;
    localparam int unsigned  IDLE_UNIT_NS     = 1000;
    localparam int unsigned  IDLE_UNIT_CYCLES = (IDLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ============================================================
    // Field encodings
    localparam logic [4:0]   CLK_SEL_BLF_2X = 5'h00;
    localparam logic [4:0]   CLK_SEL_BLF_1X = 5'h1F;
    localparam logic [1:0]   SENS_STORED    = 2'h0;
    localparam logic [7:0]   FEAT_KEEP_MASK = 8'h37;

    typedef struct packed {
        logic [1:0] rsv_hi;
        logic       no_req_rn;
        logic       no_sel_mem;
        logic       rsv_mid;
        logic       no_t2;
        logic       ack_shared;
        logic       no_xpc;
    } feat_s;

    typedef struct packed {
        logic       idle_en;
        logic [1:0] sens;
        logic [4:0] clk_sel;
        feat_s      feat;
    } ctrl_word_s;

    typedef enum logic [2:0] {
        ST_CMD,
        ST_HI,
        ST_LO,
        ST_DUMMY,
        ST_SKIP
    } parse_e;

endpackage

// ---- idle_timer.sv ----
module idle_timer
    import rf_param_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // Control
    input  wire logic        enable,
    input  wire logic        pending,
    input  wire logic [15:0] limit,
    // Result
    output logic             expire
);
    localparam logic [15:0] UNIT_LAST = 16'(IDLE_UNIT_CYCLES - 1);

    logic [15:0] pre_q;
    logic [15:0] units_q;
    logic        fired_q;
    logic        expire_q;

    wire run      = enable && pending;
    wire unit_end = (pre_q == UNIT_LAST);
    wire hit      = run && !fired_q && unit_end && (units_q == limit);

    assign expire = expire_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q    <= 16'h0000;
            units_q  <= 16'h0000;
            fired_q  <= 1'b0;
            expire_q <= 1'b0;
        end else if (ce) begin
            // Restart on every new assertion of the pending signal
            pre_q    <= (!run || unit_end) ? 16'h0000 : pre_q + 16'h0001;
            units_q  <= !run ? 16'h0000 : (unit_end && !fired_q) ? units_q + 16'h0001 : units_q;
            fired_q  <= run && (fired_q || hit);
            expire_q <= hit;
        end
    end

    only_when_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        expire |-> $past(enable && pending))
        else $error("idle expiry without enabled pending signal");

endmodule

// ---- link_clk_gen.sv ----
module link_clk_gen
    import rf_param_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // Selection
    input  wire logic [4:0] sel,
    input  wire logic       pre_query,
    input  wire logic       quiet,
    // Sources, one tick per half oscillator period and per quarter link period
    input  wire logic       osc_tick,
    input  wire logic       blf_tick,
    // Output
    output logic            link_clk
);
    logic [5:0] acc_q;
    logic       clk_q;

    wire       blf_mode = (sel == CLK_SEL_BLF_2X) || (sel == CLK_SEL_BLF_1X);
    wire       use_osc  = !blf_mode || pre_query;
    wire       tick     = use_osc ? osc_tick : blf_tick;
    // Period in ticks is den, half period den/2; fractional divisors dither between two lengths
    wire [5:0] den      = (blf_mode && pre_query) ? 6'h02 :
                          (sel == CLK_SEL_BLF_2X) ? 6'h02 :
                          (sel == CLK_SEL_BLF_1X) ? 6'h04 :
                          ({1'b0, sel} + 6'h01);
    wire [5:0] nxt      = acc_q + 6'h02;
    wire       wrap     = (nxt >= den);

    assign link_clk = clk_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 6'h00;
            clk_q <= 1'b0;
        end else if (ce) begin
            if (quiet) begin
                acc_q <= 6'h00;
                clk_q <= 1'b0;
            end else if (tick) begin
                acc_q <= wrap ? nxt - den : nxt;
                clk_q <= clk_q ^ wrap;
            end
        end
    end

    quiet_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(quiet && ce) |-> !link_clk)
        else $error("link clock toggles while quiet");

endmodule

// ---- spi_master_model.sv ----
module spi_master_model
    import rf_param_pkg::*;
(
    // Clock
    input  wire logic       pclk,
    // Byte stream into the device
    output logic            frame_active,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    // Replies from the device
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output int              reply_count,
    output logic [7:0]      reply_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        frame_active = 1'b0;
        rx_valid     = 1'b0;
        rx_byte      = 8'hA5;
        reply_count  = 0;
        reply_byte   = 8'h00;
    end

    // ============================================================
    // Reply capture
    always @(posedge pclk) begin
        if (tx_valid === 1'b1) begin
            reply_count <= reply_count + 1;
            reply_byte  <= tx_byte;
        end
    end

    // ============================================================
    // Frame of n bytes, first byte in data[31:24]
    task automatic send_frame(input logic [31:0] data, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            frame_active <= 1'b1;
            rx_valid     <= 1'b1;
            rx_byte      <= data[31-8*i -: 8];
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        // Stale byte never left on the line
        rx_byte  <= ~rx_byte;
        repeat (3) @(posedge pclk);
        frame_active <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// ---- testbench.sv ----
module testbench
    import rf_param_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_active, rx_valid, tx_valid;
    logic tag_sleep, tag_open, query_rx, boot_seq_done, serial_boot_cmd, pending, sleep_request;
    logic osc_tick, blf_tick, link_clk, sens_dummy, req_rn_reject, select_mask_only, t2_skip;
    logic ack_device, xpc_disable, err, tag_killed;
    logic [7:0]  paddr, rx_byte, tx_byte, device_status, rtn_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  sens_sel, tick_q;
    ctrl_word_s  params;
    int          miscompares, check_count, replies, n;

    spi_master_model prt_u (.pclk(pclk), .frame_active(frame_active), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .reply_count(replies),
        .reply_byte(rtn_byte));

    rf_modem_param_command dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_active(frame_active), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .device_status(device_status), .tag_sleep(tag_sleep), .tag_killed(tag_killed),
        .tag_open(tag_open), .query_rx(query_rx), .boot_seq_done(boot_seq_done),
        .serial_boot_cmd(serial_boot_cmd), .external_command_pending(pending),
        .sleep_request(sleep_request), .osc_tick(osc_tick), .blf_tick(blf_tick),
        .link_clk(link_clk), .params(params), .sens_sel(sens_sel),
        .req_rn_reject(req_rn_reject), .select_mask_only(select_mask_only), .t2_skip(t2_skip),
        .ack_device(ack_device), .xpc_disable(xpc_disable));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ============================================================
    // Oscillator tick every 2 cycles, link tick every 4
    always @(posedge pclk) begin
        tick_q   <= tick_q + 2'h1;
        osc_tick <= (tick_q[0] == 1'b0);
        blf_tick <= (tick_q == 2'h0);
    end

    // ============================================================
    // Checking and reporting
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask

    // ============================================================
    // APB master
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic load(input logic [15:0] word);
        prt_u.send_frame({CMD_SET_PARAMS, word, DUMMY_BYTE}, 4);
    endtask

    task automatic count_toggles(input int exp, input string what);
        logic last;
        int   t;
        #1;
        last = link_clk;
        t = 0;
        repeat (40) begin
            settle(1);
            t += (link_clk !== last);
            last = link_clk;
        end
        check_word(32'((t >= exp - 1) && (t <= exp + 1)), 32'h1, what);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, tick_q} = '0;
        {tag_sleep, tag_killed, tag_open, query_rx, boot_seq_done, serial_boot_cmd, pending} = '0;
        device_status = 8'h3C;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle(1);
        check_word(32'(params), 32'h0, "params after reset");
        apb(1'b0, OFS_PARAMS, 32'h0);
        check_word(rd, 32'h0, "params register after reset");
        apb(1'b1, 8'h40, 32'h1);
        check_word(32'(err), 32'h1, "unmapped access error");
        $display("TEST reset done");

        tag_open <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'hD);
        load(16'hA5FF);
        check_word(32'(replies), 32'h1, "one reply per command");
        check_word(32'(rtn_byte), 32'h3C, "reply byte");
        check_word(32'(params), 32'hA537, "stored word");
        check_word(32'(sens_sel), 32'h1, "sensitivity");
        check_word({req_rn_reject, select_mask_only, t2_skip, ack_device, xpc_disable},
                   32'h1D, "decodes shared limited open");
        apb(1'b0, OFS_PARAMS, 32'h0);
        check_word(rd, 32'h0001A537, "params register");
        $display("TEST load done");

        tag_open <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h1);
        load(16'h0000);
        check_word(32'(rtn_byte), 32'hFF, "invalid reply");
        check_word(32'(params), 32'hA537, "word kept on invalid");
        check_word({req_rn_reject, select_mask_only, t2_skip, ack_device, xpc_disable},
                   32'h0B, "decodes outside shared");
        apb(1'b0, OFS_STATUS, 32'h0);
        check_word(rd & 32'h800, 32'h800, "invalid flag");
        apb(1'b1, OFS_STATUS, 32'h800);
        apb(1'b0, OFS_STATUS, 32'h0);
        check_word(rd & 32'h800, 32'h0, "invalid flag cleared");
        prt_u.send_frame({8'hF4, 16'h0000, DUMMY_BYTE}, 4);
        check_word(32'(replies), 32'h2, "other command ignored");
        $display("TEST refusal done");

        apb(1'b1, OFS_CTRL, 32'h3);
        for (int s = 0; s < 4; s++) begin
            load({1'b0, 2'(s), 5'h01, 8'h00});
            check_word(32'(sens_sel), 32'(s), "sensitivity code");
        end
        @(posedge pclk);
        serial_boot_cmd <= 1'b1;
        @(posedge pclk);
        serial_boot_cmd <= 1'b0;
        settle(2);
        check_word(32'(params), 32'h0, "boot clears word");
        $display("TEST bypassed and boot done");

        apb(1'b1, OFS_CTRL, 32'h5);
        apb(1'b1, OFS_IDLE, 32'h1);
        load(16'h8000);
        pending <= 1'b1;
        n = 0;
        do begin
            settle(1);
            n++;
        end while (sleep_request !== 1'b1 && n < 200);
        check_word(32'((n >= 49) && (n <= 51)), 32'h1, "idle timeout length");
        @(posedge pclk);
        pending <= 1'b0;
        load(16'h0000);
        pending <= 1'b1;
        n = 0;
        repeat (80) begin
            settle(1);
            n += (sleep_request === 1'b1);
        end
        check_word(32'(n), 32'h0, "idle timeout disabled");
        @(posedge pclk);
        pending <= 1'b0;
        $display("TEST idle timer done");

        @(posedge pclk);
        query_rx <= 1'b1;
        @(posedge pclk);
        query_rx <= 1'b0;
        count_toggles(10, "twice link rate");
        load(16'h1F00);
        count_toggles(5, "link rate");
        load(16'h0300);
        count_toggles(10, "oscillator divided");
        @(posedge pclk);
        boot_seq_done <= 1'b1;
        @(posedge pclk);
        boot_seq_done <= 1'b0;
        load(16'h0000);
        count_toggles(20, "oscillator before query");
        @(posedge pclk);
        tag_sleep <= 1'b1;
        count_toggles(0, "no clock in sleep");
        check_word(32'(link_clk), 32'h0, "clock low in sleep");
        @(posedge pclk);
        tag_sleep  <= 1'b0;
        tag_killed <= 1'b1;
        count_toggles(0, "no clock when killed");
        check_word(32'(link_clk), 32'h0, "clock low when killed");
        $display("TEST link clock done");
        give_verdict();
    end
endmodule
